/* mtc_regs.svh */
// Register offsets, field positions, reset values and timing counts of the timer unit.
`ifndef MTC_REGS_SVH
`define MTC_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (one register per address, 8-bit address space)
// ----------------------------------------------------------------------------
`define MTC_ADDR_W        8
`define MTC_DATA_W        32
// Per timer n: base = n * 8.
`define MTC_TMR_STRIDE    8'h08
`define MTC_OFF_CTRL      3'h0
`define MTC_OFF_HIGH      3'h1
`define MTC_OFF_PERIOD    3'h2
`define MTC_OFF_COUNT     3'h3
`define MTC_OFF_STATUS    3'h4
`define MTC_OFF_CAP_RISE  3'h5
`define MTC_OFF_CAP_FALL  3'h6
`define MTC_ADDR_LOC      8'h40

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define MTC_CTRL_START    0
`define MTC_CTRL_STOP     1
`define MTC_CTRL_MODE_LO  2
`define MTC_CTRL_MODE_HI  4
`define MTC_CTRL_REPEAT   5
`define MTC_CTRL_RISE_EN  6
`define MTC_CTRL_PER_EN   7
`define MTC_CTRL_OUT_EN   8
`define MTC_CTRL_INV_PWM  9
`define MTC_CTRL_CAP_INV  10
`define MTC_CTRL_EDGE     11
`define MTC_CTRL_RTZ      12
`define MTC_CTRL_PRE_LO   16
`define MTC_CTRL_PRE_HI   20
`define MTC_LOC_T0        0
`define MTC_LOC_GRP       1
`define MTC_LOC_OVR       2

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define MTC_PRESCALE_MAX  5'd16
`define MTC_DS_PERIOD     17'h10000
`define MTC_LFSR_SEED     16'hACE1

`endif

/* mtc_pkg.sv */
// Types shared by the timer unit.
package mtc_pkg;

  typedef enum logic [4:0] {
    MTC_MODE_TIMER   = 5'h01,
    MTC_MODE_COUNTER = 5'h02,
    MTC_MODE_CAPTURE = 5'h04,
    MTC_MODE_DSIGMA  = 5'h08,
    MTC_MODE_IDLE    = 5'h10
  } mtc_mode_t;

  typedef struct packed {
    logic        out_en;
    logic        inv_pwm;
    logic        cap_inv;
    logic        edge_sel;
    logic        rtz;
    logic        rise_en;
    logic        per_en;
    logic        repeat_mode;
    logic [4:0]  prescale;
    logic [2:0]  mode_sel;
  } mtc_cfg_t;

  typedef struct packed {
    mtc_mode_t   mode;
    logic [15:0] count;
    logic [15:0] high_cmp;
    logic [15:0] period_cmp;
    logic [16:0] pre_cnt;
    logic [16:0] ds_cnt;
    logic [15:0] lfsr;
    logic        rtz_gap;
    logic        wave;
    logic        rise_flag;
    logic        period_flag;
    logic        rise_irq;
    logic        period_irq;
    mtc_cfg_t    cfg;
  } mtc_tmr_t;

  typedef struct packed {
    logic        cap_s1;
    logic        cap_s2;
    logic        cap_prev;
    logic        evt_s1;
    logic        evt_s2;
    logic        evt_prev;
    logic [15:0] cap_rise;
    logic [15:0] cap_fall;
    logic [2:0]  loc;
    logic [31:0] rdata;
  } mtc_com_t;

  typedef struct packed {
    logic [4:0]  pwm;
    logic [2:0]  t0_dio;
    logic [3:0]  grp_dio;
  } mtc_pins_t;

endpackage

/* mtc_timer_unit.sv */
// Five-channel timer unit with PWM, counter, capture and delta-sigma modes.
//
// Function
// RL1 - Timer zero samples its capture input on every timer tick.
// RL2 - Capture input is inverted before measurement when capture_invert is set.
// RL3 - Only timer zero captures; timers one to four never do.
// RL4 - Counter counts rising edges, or both edges when edge_select is set.
// RL5 - Event counting exists only on timer zero.
// RL6 - Software sets inversion and edge selection before starting the timer.
// RL7 - Timer zero pins move from default group to alternative group on pin_location_select.
// RL8 - Timers one to four relocate together as one group.
// RL9 - output_override_select routes timers three and two to digital outputs.
// RL10 - Single shot: low, high at high_compare, low at period_compare, then stop.
// RL11 - Repeat mode restarts the pulse cycle each period until stopped.
// RL12 - Rise and period interrupts at output edges, each when enabled.
// RL13 - Counter single shot: interrupts at both compares, stop at period_compare.
// RL14 - Counter repeat: period interrupt and restart from zero; rise still occurs.
// RL15 - The current count can be read any time without disturbance.
// RL16 - Capture records cycles to latest rising and latest falling transitions.
// RL17 - Both capture results are held in readable registers.
// RL18 - Delta-sigma runs on the undivided clock, period 65536 cycles.
// RL19 - Delta-sigma emits conversion-value random single-cycle pulses per period.
// RL20 - Return-to-zero inserts a low cycle after each cycle, doubling period.
// RL21 - Software enables pin output before using delta-sigma mode.
// RL22 - Timer clock is source divided by two to the prescale index, 0 to 16.
// RL23 - PWM output inversion drives the complement of the waveform.
// RL24 - Counters and compares are 16 bits; inputs are synchronised first.
// RL25 - Starting any mode clears the counter and drives the output low.
`timescale 1ns/10ps
`include "mtc_regs.svh"

module mtc_timer_unit
  import mtc_pkg::*;
#(
  parameter int NUM_TIMERS = 5
) (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  // Register port
  input  wire logic [`MTC_ADDR_W-1:0]   i_addr,
  input  wire logic [`MTC_DATA_W-1:0]   i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [`MTC_DATA_W-1:0]   o_rdata,
  // External inputs of timer zero
  input  wire logic                     i_capture_input_pin,
  input  wire logic                     i_event_input,
  // Timer events
  output logic      [NUM_TIMERS-1:0]    o_rise_interrupt,
  output logic      [NUM_TIMERS-1:0]    o_period_interrupt,
  // Pin outputs
  output logic      [NUM_TIMERS-1:0]    o_pwm,
  output logic      [2:0]               o_t0_dio_default,
  output logic      [2:0]               o_t0_dio_alt,
  output logic      [3:0]               o_grp_dio_default,
  output logic      [3:0]               o_grp_dio_alt,
  output logic                          o_digital_output_zero,
  output logic                          o_digital_output_one,
  output logic                          o_t0_alt_location,
  output logic                          o_grp_alt_location
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  mtc_tmr_t  tmr_reg  [NUM_TIMERS];
  mtc_tmr_t  tmr_next [NUM_TIMERS];
  mtc_com_t  com_reg;
  mtc_com_t  com_next;
  mtc_pins_t pins_reg;
  mtc_pins_t pins_next;

  logic [NUM_TIMERS-1:0] tick;
  logic cap_level;
  logic cap_rise_edge;
  logic cap_fall_edge;
  logic evt_edge;
  logic [2:0] wsel;
  logic [4:0] tsel;

  assign tsel = 5'(i_addr[7:3]);
  assign wsel = i_addr[2:0];

  // The second stage feeds the edge detectors both directly and through cap_prev.
  assign cap_level     = com_reg.cap_s2 ^ tmr_reg[0].cfg.cap_inv; // RL2
  assign cap_rise_edge = cap_level & ~com_reg.cap_prev;
  assign cap_fall_edge = ~cap_level & com_reg.cap_prev;
  assign evt_edge      = tmr_reg[0].cfg.edge_sel ? (com_reg.evt_s2 ^ com_reg.evt_prev) // RL4
                                                 : (com_reg.evt_s2 & ~com_reg.evt_prev);

  // --------------------------------------------------------------------------
  // Per-timer logic
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
      always_comb begin
        mtc_tmr_t   n;
        logic [16:0] div;
        logic       wr_hit;
        logic       hit_hi;
        logic       hit_per;
        n      = tmr_reg[g];
        div    = 17'h1 << tmr_reg[g].cfg.prescale;
        wr_hit = i_wr && (tsel == 5'(g));
        n.rise_irq   = 1'b0;
        n.period_irq = 1'b0;
        // Prescaler: one enable pulse every 2^prescale clocks.
        tick[g] = 1'b0;
        if (tmr_reg[g].mode != MTC_MODE_IDLE) begin
          if (tmr_reg[g].pre_cnt >= div - 17'h1) begin // RL22
            n.pre_cnt = 17'h0;
            tick[g]   = 1'b1;
          end else begin
            n.pre_cnt = tmr_reg[g].pre_cnt + 17'h1;
          end
        end
        hit_hi  = (tmr_reg[g].count + 16'h1) == tmr_reg[g].high_cmp;
        hit_per = (tmr_reg[g].count + 16'h1) == tmr_reg[g].period_cmp;
        case (tmr_reg[g].mode)
          MTC_MODE_TIMER: begin
            if (tick[g]) begin
              n.count = tmr_reg[g].count + 16'h1;
              if (hit_hi) begin
                n.wave     = 1'b1;
                n.rise_irq = tmr_reg[g].cfg.rise_en; // RL12
              end
              if (hit_per) begin
                n.wave       = 1'b0;
                n.period_irq = tmr_reg[g].cfg.per_en; // RL12
                n.count      = 16'h0;
                if (!tmr_reg[g].cfg.repeat_mode) begin
                  n.mode = MTC_MODE_IDLE; // RL10 RL11
                end
              end
            end
          end
          MTC_MODE_COUNTER: begin
            if (g == 0 && evt_edge) begin // RL5
              n.count = tmr_reg[g].count + 16'h1;
              if (hit_hi) begin
                n.rise_irq = tmr_reg[g].cfg.rise_en; // RL13
              end
              if (hit_per) begin
                n.period_irq = tmr_reg[g].cfg.per_en; // RL13
                if (tmr_reg[g].cfg.repeat_mode) begin
                  n.count = 16'h0; // RL14
                end else begin
                  n.mode = MTC_MODE_IDLE; // RL13
                end
              end
            end
          end
          MTC_MODE_CAPTURE: begin
            if (g == 0 && tick[g]) begin // RL1 RL3
              n.count = tmr_reg[g].count + 16'h1;
            end
          end
          MTC_MODE_DSIGMA: begin
            // Undivided clock; RTZ forces a low cycle after every output cycle.
            n.pre_cnt = 17'h0; // RL18
            if (tmr_reg[g].rtz_gap) begin
              n.rtz_gap = 1'b0;
              n.wave    = 1'b0;
            end else begin
              n.rtz_gap = tmr_reg[g].cfg.rtz; // RL20
              n.lfsr    = {tmr_reg[g].lfsr[14:0], tmr_reg[g].lfsr[15] ^ tmr_reg[g].lfsr[13]
                           ^ tmr_reg[g].lfsr[12] ^ tmr_reg[g].lfsr[10]};
              // Permuted LFSR word is compared against the value: pulses land at random.
              n.wave    = {tmr_reg[g].lfsr[7:0], tmr_reg[g].lfsr[15:8]} < tmr_reg[g].high_cmp; // RL19
              n.ds_cnt  = (tmr_reg[g].ds_cnt == `MTC_DS_PERIOD - 17'h1) ? 17'h0
                                                                        : tmr_reg[g].ds_cnt + 17'h1;
              n.count   = 16'(n.ds_cnt);
            end
          end
          MTC_MODE_IDLE: begin
            n.wave = 1'b0;
          end
          default: begin
            n.mode = MTC_MODE_IDLE;
          end
        endcase
        // Sticky flags, hardware set wins over software clear.
        if (wr_hit && wsel == `MTC_OFF_STATUS) begin
          n.rise_flag   = tmr_reg[g].rise_flag & ~i_wdata[0];
          n.period_flag = tmr_reg[g].period_flag & ~i_wdata[1];
        end
        n.rise_flag   = n.rise_flag | n.rise_irq;
        n.period_flag = n.period_flag | n.period_irq;
        if (wr_hit && wsel == `MTC_OFF_HIGH) begin
          n.high_cmp = i_wdata[15:0];
        end
        if (wr_hit && wsel == `MTC_OFF_PERIOD) begin
          n.period_cmp = i_wdata[15:0];
        end
        if (wr_hit && wsel == `MTC_OFF_CTRL) begin
          n.cfg.repeat_mode = i_wdata[`MTC_CTRL_REPEAT];
          n.cfg.rise_en     = i_wdata[`MTC_CTRL_RISE_EN];
          n.cfg.per_en      = i_wdata[`MTC_CTRL_PER_EN];
          n.cfg.out_en      = i_wdata[`MTC_CTRL_OUT_EN];
          n.cfg.inv_pwm     = i_wdata[`MTC_CTRL_INV_PWM];
          n.cfg.cap_inv     = (g == 0) && i_wdata[`MTC_CTRL_CAP_INV];
          n.cfg.edge_sel    = (g == 0) && i_wdata[`MTC_CTRL_EDGE];
          n.cfg.rtz         = i_wdata[`MTC_CTRL_RTZ];
          n.cfg.mode_sel    = i_wdata[`MTC_CTRL_MODE_HI:`MTC_CTRL_MODE_LO];
          n.cfg.prescale    = (i_wdata[`MTC_CTRL_PRE_HI:`MTC_CTRL_PRE_LO] > `MTC_PRESCALE_MAX)
                              ? `MTC_PRESCALE_MAX : i_wdata[`MTC_CTRL_PRE_HI:`MTC_CTRL_PRE_LO];
          if (i_wdata[`MTC_CTRL_STOP]) begin
            n.mode = MTC_MODE_IDLE;
            n.wave = 1'b0;
          end else if (i_wdata[`MTC_CTRL_START]) begin
            n.count   = 16'h0; // RL25
            n.wave    = 1'b0;
            n.pre_cnt = 17'h0;
            n.ds_cnt  = 17'h0;
            n.rtz_gap = 1'b0;
            case (i_wdata[`MTC_CTRL_MODE_HI:`MTC_CTRL_MODE_LO])
              3'h0: n.mode = MTC_MODE_TIMER;
              3'h1: n.mode = (g == 0) ? MTC_MODE_COUNTER : MTC_MODE_IDLE; // RL5
              3'h2: n.mode = (g == 0) ? MTC_MODE_CAPTURE : MTC_MODE_IDLE; // RL3
              3'h3: n.mode = MTC_MODE_DSIGMA;
              default: n.mode = MTC_MODE_IDLE;
            endcase
          end
        end
        tmr_next[g] = n;
      end

      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          tmr_reg[g] <= '{mode: MTC_MODE_IDLE, lfsr: `MTC_LFSR_SEED, default: '0};
        end else begin
          tmr_reg[g] <= tmr_next[g];
        end
      end

      assign o_rise_interrupt[g]   = tmr_reg[g].rise_irq;
      assign o_period_interrupt[g] = tmr_reg[g].period_irq;
      assign o_pwm[g]              = pins_reg.pwm[g];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Shared inputs, capture, pin routing and read port
  // --------------------------------------------------------------------------
  always_comb begin
    mtc_tmr_t t;
    com_next        = com_reg;
    com_next.cap_s1 = i_capture_input_pin;
    com_next.cap_s2 = com_reg.cap_s1; // RL24
    com_next.evt_s1 = i_event_input;
    com_next.evt_s2 = com_reg.evt_s1; // RL24
    com_next.evt_prev = com_reg.evt_s2;
    if (tmr_reg[0].mode == MTC_MODE_CAPTURE && tick[0]) begin
      com_next.cap_prev = cap_level; // RL1
      if (cap_rise_edge) begin
        com_next.cap_rise = tmr_reg[0].count; // RL16 RL17
      end
      if (cap_fall_edge) begin
        com_next.cap_fall = tmr_reg[0].count; // RL16 RL17
      end
    end
    if (i_wr && i_addr == `MTC_ADDR_LOC) begin
      com_next.loc = i_wdata[2:0];
    end
    if (i_wr && tsel == 5'h0 && wsel == `MTC_OFF_CTRL && i_wdata[`MTC_CTRL_START]) begin
      com_next.cap_rise = 16'h0;
      com_next.cap_fall = 16'h0;
      com_next.cap_prev = com_reg.cap_s2 ^ i_wdata[`MTC_CTRL_CAP_INV];
    end
    com_next.rdata = '0;
    t = tmr_reg[0];
    for (int k = 0; k < NUM_TIMERS; k++) begin
      if (tsel == 5'(k)) begin
        t = tmr_reg[k];
      end
    end
    if (i_rd) begin
      if (i_addr == `MTC_ADDR_LOC) begin
        com_next.rdata = {29'h0, com_reg.loc};
      end else if (tsel < 5'(NUM_TIMERS)) begin
        case (wsel)
          `MTC_OFF_CTRL: com_next.rdata = {11'h0, t.cfg.prescale, 3'h0, t.cfg.rtz, t.cfg.edge_sel,
                                          t.cfg.cap_inv, t.cfg.inv_pwm, t.cfg.out_en, t.cfg.per_en,
                                          t.cfg.rise_en, t.cfg.repeat_mode, t.cfg.mode_sel,
                                          1'b0, t.mode != MTC_MODE_IDLE};
          `MTC_OFF_HIGH:     com_next.rdata = {16'h0, t.high_cmp};
          `MTC_OFF_PERIOD:   com_next.rdata = {16'h0, t.period_cmp};
          `MTC_OFF_COUNT:    com_next.rdata = {16'h0, t.count}; // RL15
          `MTC_OFF_STATUS:   com_next.rdata = {30'h0, t.period_flag, t.rise_flag};
          `MTC_OFF_CAP_RISE: com_next.rdata = (tsel == 5'h0) ? {16'h0, com_reg.cap_rise} : 32'h0;
          `MTC_OFF_CAP_FALL: com_next.rdata = (tsel == 5'h0) ? {16'h0, com_reg.cap_fall} : 32'h0;
          default:           com_next.rdata = 32'h0;
        endcase
      end
    end
  end

  always_comb begin
    logic [4:0] w;
    w = '0;
    for (int k = 0; k < NUM_TIMERS; k++) begin
      w[k] = tmr_reg[k].cfg.out_en & (tmr_reg[k].wave ^ tmr_reg[k].cfg.inv_pwm); // RL23 RL21
    end
    pins_next.pwm = w;
    pins_next.t0_dio = {w[0], cap_level, com_reg.evt_s2};
    pins_next.grp_dio = {w[4], w[3] & ~com_next.loc[`MTC_LOC_OVR], w[2] & ~com_next.loc[`MTC_LOC_OVR], w[1]};
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      com_reg  <= '0;
      pins_reg <= '0;
    end else begin
      com_reg  <= com_next;
      pins_reg <= pins_next;
    end
  end

  // Pin group selection; only the PWM bit of timer zero is an output.
  assign o_t0_alt_location     = com_reg.loc[`MTC_LOC_T0]; // RL7
  assign o_grp_alt_location    = com_reg.loc[`MTC_LOC_GRP]; // RL8
  assign o_t0_dio_default      = com_reg.loc[`MTC_LOC_T0] ? 3'h0 : {pins_reg.t0_dio[2], 2'h0}; // RL7
  assign o_t0_dio_alt          = com_reg.loc[`MTC_LOC_T0] ? {pins_reg.t0_dio[2], 2'h0} : 3'h0;
  assign o_grp_dio_default     = com_reg.loc[`MTC_LOC_GRP] ? 4'h0 : pins_reg.grp_dio; // RL8
  assign o_grp_dio_alt         = com_reg.loc[`MTC_LOC_GRP] ? pins_reg.grp_dio : 4'h0;
  assign o_digital_output_zero = com_reg.loc[`MTC_LOC_OVR] & pins_reg.pwm[2]; // RL9
  assign o_digital_output_one  = com_reg.loc[`MTC_LOC_OVR] & pins_reg.pwm[3]; // RL9
  assign o_rdata               = com_reg.rdata;

endmodule

/* mtc_timer_unit_properties.sv */
// Port-level assertions of the timer unit, bound to its top module.
`timescale 1ns/10ps
`include "mtc_regs.svh"

module mtc_timer_unit_properties #(
  parameter int NUM_TIMERS = 5
) (
  // Clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_rst_n,
  // Register port
  input wire logic [`MTC_ADDR_W-1:0] i_addr,
  input wire logic [`MTC_DATA_W-1:0] i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [`MTC_DATA_W-1:0] o_rdata,
  // External inputs
  input wire logic                   i_capture_input_pin,
  input wire logic                   i_event_input,
  // Events and pins
  input wire logic [NUM_TIMERS-1:0]  o_rise_interrupt,
  input wire logic [NUM_TIMERS-1:0]  o_period_interrupt,
  input wire logic [NUM_TIMERS-1:0]  o_pwm,
  input wire logic [2:0]             o_t0_dio_default,
  input wire logic [2:0]             o_t0_dio_alt,
  input wire logic [3:0]             o_grp_dio_default,
  input wire logic [3:0]             o_grp_dio_alt,
  input wire logic                   o_digital_output_zero,
  input wire logic                   o_digital_output_one,
  input wire logic                   o_t0_alt_location,
  input wire logic                   o_grp_alt_location
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  rdata_idle_zero_a: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data seen outside a read slot");
  cap_absent_a: assert property (
    i_rd && i_addr[7:3] inside {[5'h1:5'h4]} &&
    (i_addr[2:0] == `MTC_OFF_CAP_RISE || i_addr[2:0] == `MTC_OFF_CAP_FALL) |=> o_rdata == 32'h0)
    else $error("capture result on a timer without inputs");
  unmapped_read_a: assert property (
    i_rd && i_addr > `MTC_ADDR_LOC |=> o_rdata == 32'h0)
    else $error("unmapped address returned data");
  t0_default_off_a: assert property (
    o_t0_alt_location |-> o_t0_dio_default == 3'h0)
    else $error("timer zero default pins driven in alternative placement");
  t0_alt_off_a: assert property (
    !o_t0_alt_location |-> o_t0_dio_alt == 3'h0)
    else $error("timer zero alternative pins driven in default placement");
  grp_default_off_a: assert property (
    o_grp_alt_location |-> o_grp_dio_default == 4'h0)
    else $error("group default pins driven in alternative placement");
  grp_alt_off_a: assert property (
    !o_grp_alt_location |-> o_grp_dio_alt == 4'h0)
    else $error("group alternative pins driven in default placement");
  dout_zero_src_a: assert property (
    o_digital_output_zero |-> o_pwm[2] && !o_grp_dio_default[1] && !o_grp_dio_alt[1])
    else $error("digital output zero does not carry timer two alone");
  dout_one_src_a: assert property (
    o_digital_output_one |-> o_pwm[3] && !o_grp_dio_default[2] && !o_grp_dio_alt[2])
    else $error("digital output one does not carry timer three alone");
endmodule

bind mtc_timer_unit mtc_timer_unit_properties #(.NUM_TIMERS(NUM_TIMERS)) u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_capture_input_pin(i_capture_input_pin), .i_event_input(i_event_input),
  .o_rise_interrupt(o_rise_interrupt), .o_period_interrupt(o_period_interrupt), .o_pwm(o_pwm),
  .o_t0_dio_default(o_t0_dio_default), .o_t0_dio_alt(o_t0_dio_alt), .o_grp_dio_default(o_grp_dio_default),
  .o_grp_dio_alt(o_grp_dio_alt), .o_digital_output_zero(o_digital_output_zero),
  .o_digital_output_one(o_digital_output_one), .o_t0_alt_location(o_t0_alt_location),
  .o_grp_alt_location(o_grp_alt_location));

/* mtc_ext_src.sv */
// External pulse sources that feed the capture and event inputs of timer zero.
`timescale 1ns/10ps

module mtc_ext_src (
  // Clock
  input  wire logic i_clk,
  // Stimulus pins
  output logic      o_capture_input_pin,
  output logic      o_event_input
);
  initial begin
    o_capture_input_pin = 1'b0;
    o_event_input = 1'b0;
  end

  // One high pulse after a low stretch; the pin ends low.
  task automatic cap_pulse(input int lo, input int hi);
    repeat (lo) @(posedge i_clk);
    o_capture_input_pin <= 1'b1;
    repeat (hi) @(posedge i_clk);
    o_capture_input_pin <= 1'b0;
  endtask

  // A train of n pulses, w cycles low then w cycles high each.
  task automatic evt_pulses(input int n, input int w);
    repeat (n) begin
      repeat (w) @(posedge i_clk);
      o_event_input <= 1'b1;
      repeat (w) @(posedge i_clk);
      o_event_input <= 1'b0;
    end
  endtask
endmodule

/* multimode_timer_capture_counter_tb_top.sv */
// Self-checking testbench of the timer unit.
`timescale 1ns/10ps
`include "mtc_regs.svh"

module multimode_timer_capture_counter_tb_top;
  logic        i_clk;
  logic        i_rst_n;
  logic        i_wr;
  logic        i_rd;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic [31:0] o_rdata;
  logic        cap, evt, t0_alt, grp_alt;
  logic [4:0]  rise, per, pwm;
  logic [5:0]  pins;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          act;
  int          dbl;
  int          rq[$];
  int          pq[$];
  localparam logic [31:0] STOP = 32'h1 << `MTC_CTRL_STOP;
  localparam logic [31:0] REP = 32'h1 << `MTC_CTRL_REPEAT;
  localparam logic [31:0] RIE = 32'h1 << `MTC_CTRL_RISE_EN;
  localparam logic [31:0] PIE = 32'h1 << `MTC_CTRL_PER_EN;
  localparam logic [31:0] OEN = 32'h1 << `MTC_CTRL_OUT_EN;
  localparam logic [31:0] INV = 32'h1 << `MTC_CTRL_INV_PWM;
  localparam logic [31:0] CINV = 32'h1 << `MTC_CTRL_CAP_INV;
  localparam logic [31:0] EDG = 32'h1 << `MTC_CTRL_EDGE;
  localparam logic [31:0] RTZ = 32'h1 << `MTC_CTRL_RTZ;

  mtc_timer_unit dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_capture_input_pin(cap), .i_event_input(evt), .o_rise_interrupt(rise),
    .o_period_interrupt(per), .o_pwm(pwm), .o_t0_dio_default(), .o_t0_dio_alt(), .o_grp_dio_default(pins[5:2]),
    .o_grp_dio_alt(), .o_digital_output_zero(pins[0]), .o_digital_output_one(pins[1]), .o_t0_alt_location(t0_alt),
    .o_grp_alt_location(grp_alt));
  mtc_ext_src ext (.i_clk(i_clk), .o_capture_input_pin(cap), .o_event_input(evt));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ----
  // Bus, compare and measurement tasks
  // ----
  function automatic logic [7:0] ad(int t, int o);
    return 8'(t * 8 + o);
  endfunction
  function automatic logic [31:0] cw(int mode, int pre, logic [31:0] fl);
    return fl | 32'h1 | (32'(mode) << `MTC_CTRL_MODE_LO) | (32'(pre) << `MTC_CTRL_PRE_LO);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic go(input int t, input logic [15:0] hc, input logic [15:0] pc, input logic [31:0] c);
    wr(ad(t, 1), {16'h0, hc});
    wr(ad(t, 2), {16'h0, pc});
    wr(ad(t, 0), c);
  endtask
  task automatic measure(input int t, input int n, input logic inv);
    logic prev;
    prev = 1'b0;
    act = 0;
    dbl = 0;
    rq.delete();
    pq.delete();
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      #1;
      if (rise[t] === 1'b1) rq.push_back(i);
      if (per[t] === 1'b1) pq.push_back(i);
      if ((pwm[t] ^ inv) === 1'b1) act++;
      if (prev && pwm[t] === 1'b1) dbl++;
      prev = (pwm[t] === 1'b1);
    end
  endtask
  task automatic count_run(input int t, input int n, input int len);
    fork
      ext.evt_pulses(n, 4);
      measure(t, len, 1'b0);
    join
  endtask

  // ----
  // Scenarios
  // ----
  task automatic test_regs();
    logic [31:0] d;
    wr(ad(1, 1), 32'h0001_1234);
    rd(ad(1, 1), d);
    chk(d, 32'h0000_1234);
    rd(8'h47, d);
    chk(d, 32'h0);
    for (int t = 1; t < 5; t++) begin
      rd(ad(t, 5), d);
      chk(d, 32'h0);
      rd(ad(t, 6), d);
      chk(d, 32'h0);
    end
    wr(`MTC_ADDR_LOC, 32'h3);
    @(posedge i_clk);
    #1;
    chk({30'h0, t0_alt, grp_alt}, 32'h3);
    wr(`MTC_ADDR_LOC, 32'h4);
  endtask
  task automatic test_single();
    int   tt[4] = '{0, 0, 2, 3};
    int   pp[4] = '{0, 2, 1, 0};
    logic iv[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic re[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    for (int k = 0; k < 4; k++) begin
      go(tt[k], 3, 6, cw(0, pp[k], (re[k] ? RIE : 32'h0) | PIE | OEN | (iv[k] ? INV : 32'h0)));
      measure(tt[k], 12 + (8 << pp[k]), iv[k]);
      chk(rq.size(), re[k]);
      chk(pq.size(), 1);
      chk(act, 3 << pp[k]);
      if (re[k]) chk(pq[0] - rq[0], 3 << pp[k]);
    end
    chk({26'h0, pins}, 32'h1);
  endtask
  task automatic test_repeat();
    go(1, 2, 5, cw(0, 0, REP | RIE | PIE | OEN));
    measure(1, 30, 1'b0);
    chk(rq[1] - rq[0], 5);
    chk(pq[1] - pq[0], 5);
    chk(pq[0] - rq[0], 3);
    wr(ad(1, 0), STOP);
    measure(1, 20, 1'b0);
    chk(rq.size() + pq.size(), 0);
  endtask
  task automatic test_counter();
    logic [31:0] d;
    go(0, 3, 6, cw(1, 0, RIE | PIE));
    count_run(0, 5, 60);
    chk(rq.size() + 2 * pq.size(), 1);
    rd(ad(0, 3), d);
    chk(d, 32'h5);
    go(0, 3, 6, cw(1, 0, RIE | PIE | EDG));
    count_run(0, 3, 40);
    chk(rq.size() + 2 * pq.size(), 3);
    go(0, 3, 6, cw(1, 0, REP | RIE | PIE));
    count_run(0, 12, 120);
    chk(rq.size() + 4 * pq.size(), 10);
    rd(ad(0, 3), d);
    chk(d, 32'h0);
    go(1, 1, 2, cw(1, 0, RIE | PIE));
    count_run(1, 4, 50);
    chk(rq.size() + pq.size(), 0);
  endtask
  task automatic test_capture();
    logic [31:0] r;
    logic [31:0] f;
    for (int k = 0; k < 2; k++) begin
      go(0, 0, 0, cw(2, 0, k ? CINV : 32'h0));
      ext.cap_pulse(10, 7);
      repeat (10) @(posedge i_clk);
      rd(ad(0, 5), r);
      rd(ad(0, 6), f);
      chk({16'h0, k ? r[15:0] - f[15:0] : f[15:0] - r[15:0]}, 32'h7);
    end
  endtask
  task automatic test_dsigma();
    go(3, 0, 0, cw(3, 0, OEN));
    measure(3, 2000, 1'b0);
    chk(act, 0);
    go(2, 16'hFFFF, 0, cw(3, 0, OEN | RTZ));
    measure(2, 2000, 1'b0);
    chk(dbl, 0);
    chk(act > 900, 1);
    go(3, 16'h4000, 0, cw(3, 0, OEN));
    measure(3, 65536, 1'b0);
    chk(act >= 16368 && act <= 16400, 1);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    test_regs();
    test_single();
    test_repeat();
    test_counter();
    test_capture();
    test_dsigma();
    give_verdict();
  end
endmodule
